// ### core/nco_pkg.sv
// constants, types and helpers for the oscillator control block
// Behaviour
// RL1: The oscillator runs while the enable bit (bit 7) is one and holds still while it is zero.
// RL2: Bit 5 of the control register reads back the live oscillator output level and cannot be written.
// RL3: The output is inverted when bit 4 is one and passed straight when it is zero.
// RL4: Bit 0 selects pulse frequency mode when one and fixed duty mode when zero.
// RL5: Bit 6 and bits 3 to 1 of the control register always read as zero.
// RL6: Each clock edge adds the 20-bit increment to the accumulator and the carry out is the overflow event.
// RL7: In fixed duty mode the output toggles on each overflow, giving a square wave at half the overflow rate.
// RL8: In pulse frequency mode the output goes active at the edge after an overflow for the selected number of periods.
// RL9: Every oscillator register, the control register included, is cleared to zero by reset.
// RL10: Writes to the status bit and to the unused control bits have no effect.
package nco_pkg;

    localparam int NCO_AW = 3;
    localparam int NCO_DW = 8;
    localparam int NCO_ACC_W = 20;
    localparam int NCO_PWS_W = 3;
    localparam int NCO_CNT_W = 7;

    // register map
    localparam logic [NCO_AW-1:0] NCO_ADDR_CON = 3'h0;
    localparam logic [NCO_AW-1:0] NCO_ADDR_INCL = 3'h1;
    localparam logic [NCO_AW-1:0] NCO_ADDR_INCH = 3'h2;
    localparam logic [NCO_AW-1:0] NCO_ADDR_INCU = 3'h3;
    localparam logic [NCO_AW-1:0] NCO_ADDR_PWS = 3'h4;
    localparam logic [NCO_AW-1:0] NCO_ADDR_ACCL = 3'h5;
    localparam logic [NCO_AW-1:0] NCO_ADDR_ACCH = 3'h6;
    localparam logic [NCO_AW-1:0] NCO_ADDR_ACCU = 3'h7;

    // control register fields
    localparam int NCO_BIT_EN = 7;
    localparam int NCO_BIT_OUT = 5;
    localparam int NCO_BIT_POL = 4;
    localparam int NCO_BIT_PFM = 0;
    localparam logic [NCO_DW-1:0] NCO_CON_RMASK = 8'hb1;
    localparam logic [NCO_DW-1:0] NCO_RST_BYTE = 8'h00;
    localparam int NCO_INCU_W = 4;

    typedef struct packed {
        logic osc_enable;
        logic output_invert;
        logic pulse_frequency_select;
    } nco_ctrl_t;

    localparam nco_ctrl_t NCO_CTRL_RST = '{1'b0, 1'b0, 1'b0};

    // control byte as software sees it; unused positions stay zero
    function automatic logic [NCO_DW-1:0] nco_con_byte(nco_ctrl_t c,
                                                       logic level);
        logic [NCO_DW-1:0] b;
        b = NCO_RST_BYTE;
        b[NCO_BIT_EN] = c.osc_enable;
        b[NCO_BIT_OUT] = level;
        b[NCO_BIT_POL] = c.output_invert;
        b[NCO_BIT_PFM] = c.pulse_frequency_select;
        return b;
    endfunction

    // writable part of a control byte
    function automatic nco_ctrl_t nco_con_decode(logic [NCO_DW-1:0] d);
        nco_ctrl_t c;
        c.osc_enable = d[NCO_BIT_EN];
        c.output_invert = d[NCO_BIT_POL];
        c.pulse_frequency_select = d[NCO_BIT_PFM];
        return c;
    endfunction

endpackage

// ### core/nco_pulse.sv
// output shaping stage: toggle or stretched pulse per overflow
`timescale 1ns/1ns
module nco_pulse #(
    parameter int PWS_W = nco_pkg::NCO_PWS_W,
    parameter int CNT_W = nco_pkg::NCO_CNT_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // settings
    input wire nco_pkg::nco_ctrl_t ctrl,
    input wire logic [PWS_W-1:0] pulse_width_sel,
    // overflow event
    input wire logic accumulator_carry,
    // shaped level before polarity
    output logic raw_level
);
    import nco_pkg::*;

    logic raw_level_ff;
    logic nxt_raw_level;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] width_m1;
    logic cnt_zero;

    // width is 2**sel periods; the count holds periods left after this one
    assign width_m1 = CNT_W'((1 << pulse_width_sel) - 1);
    assign cnt_zero = (cnt_ff == '0);

    always_comb begin
        nxt_raw_level = raw_level_ff;
        nxt_cnt = cnt_ff;
        if (!ctrl.osc_enable) begin
            // a stopped oscillator parks its output inactive
            nxt_raw_level = 1'b0;
            nxt_cnt = '0;
        end else if (!ctrl.pulse_frequency_select) begin
            nxt_cnt = '0;
            if (accumulator_carry) begin
                nxt_raw_level = ~raw_level_ff; // see RL7
            end
        end else if (accumulator_carry) begin
            // a new overflow restarts the pulse, so a long width never drops
            nxt_raw_level = 1'b1; // see RL8
            nxt_cnt = width_m1;
        end else if (!cnt_zero) begin
            nxt_cnt = cnt_ff - CNT_W'(1);
        end else begin
            nxt_raw_level = 1'b0; // see RL8
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            raw_level_ff <= 1'b0;
            cnt_ff <= '0;
        end else begin
            raw_level_ff <= nxt_raw_level;
            cnt_ff <= nxt_cnt;
        end
    end

    assign raw_level = raw_level_ff;

    a_fdc_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl.osc_enable && !ctrl.pulse_frequency_select && accumulator_carry
        |=> raw_level_ff != $past(raw_level_ff)) // see RL7
        else $error("fixed duty output did not toggle on overflow");

    a_pulse_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl.osc_enable && ctrl.pulse_frequency_select && accumulator_carry
        |=> raw_level_ff) // see RL8
        else $error("pulse did not start after overflow");

    a_pulse_width1: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl.osc_enable && ctrl.pulse_frequency_select && accumulator_carry
        && pulse_width_sel == '0 ##1 ctrl.osc_enable && !accumulator_carry
        |=> !raw_level_ff) // see RL8
        else $error("single period pulse too long");

endmodule // nco_pulse

// ### core/nco_core.sv
// oscillator control register, accumulator and output stage
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module nco_core #(
    parameter int ACC_W = nco_pkg::NCO_ACC_W,
    parameter int PWS_W = nco_pkg::NCO_PWS_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [nco_pkg::NCO_AW-1:0] reg_addr,
    input wire logic [nco_pkg::NCO_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [nco_pkg::NCO_DW-1:0] reg_rdata,
    // oscillator outputs
    output logic nco_out,
    output logic accumulator_carry
);
    import nco_pkg::*;

    // reset release synchroniser
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    // register state
    nco_ctrl_t ctrl_ff;
    nco_ctrl_t nxt_ctrl;
    logic [NCO_DW-1:0] incl_ff;
    logic [NCO_DW-1:0] inch_ff;
    logic [NCO_INCU_W-1:0] incu_ff;
    logic [PWS_W-1:0] pws_ff;
    logic [ACC_W-1:0] inc_buf_ff;
    logic [ACC_W-1:0] nxt_inc_buf;
    logic inc_load_ff;
    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] nxt_acc;
    logic carry_ff;
    logic out_ff;
    logic nxt_out;
    logic [NCO_DW-1:0] rdata_ff;
    logic [NCO_DW-1:0] nxt_rdata;

    // decode
    logic wr_con;
    logic wr_incl;
    logic wr_inch;
    logic wr_incu;
    logic wr_pws;
    logic [ACC_W-1:0] inc_staged;
    logic [ACC_W:0] sum;
    logic carry;
    logic raw_level;

    assign wr_con = reg_wr && (reg_addr == NCO_ADDR_CON);
    assign wr_incl = reg_wr && (reg_addr == NCO_ADDR_INCL);
    assign wr_inch = reg_wr && (reg_addr == NCO_ADDR_INCH);
    assign wr_incu = reg_wr && (reg_addr == NCO_ADDR_INCU);
    assign wr_pws = reg_wr && (reg_addr == NCO_ADDR_PWS);

    // only enable, polarity and mode are stored; other bits are dropped
    assign nxt_ctrl = wr_con ? nco_con_decode(reg_wdata) : ctrl_ff; // see RL10

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= NCO_CTRL_RST; // see RL9
        end else begin
            ctrl_ff <= nxt_ctrl; // see RL1
        end
    end

    // increment staging; the low byte write arms the buffer load
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            incl_ff <= NCO_RST_BYTE;
            inch_ff <= NCO_RST_BYTE;
            incu_ff <= '0;
            pws_ff <= '0;
        end else begin
            if (wr_incl) incl_ff <= reg_wdata;
            if (wr_inch) inch_ff <= reg_wdata;
            if (wr_incu) incu_ff <= reg_wdata[NCO_INCU_W-1:0];
            if (wr_pws) pws_ff <= reg_wdata[PWS_W-1:0];
        end
    end

    assign inc_staged = {incu_ff, inch_ff, incl_ff};

    // running: load on the second edge after the low byte write, so the
    // adder never sees half an update; stopped: load right away
    assign nxt_inc_buf = (inc_load_ff && ctrl_ff.osc_enable) ? inc_staged :
                         (!ctrl_ff.osc_enable) ? inc_staged : inc_buf_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            inc_buf_ff <= '0;
            inc_load_ff <= 1'b0;
        end else begin
            inc_buf_ff <= nxt_inc_buf;
            inc_load_ff <= wr_incl && ctrl_ff.osc_enable;
        end
    end

    // accumulator; holds its value while stopped
    assign sum = {1'b0, acc_ff} + {1'b0, inc_buf_ff}; // see RL6
    assign carry = ctrl_ff.osc_enable && sum[ACC_W]; // see RL6
    assign nxt_acc = ctrl_ff.osc_enable ? sum[ACC_W-1:0] : acc_ff; // see RL1

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= '0; // see RL9
            carry_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            carry_ff <= carry;
        end
    end

    nco_pulse #(
        .PWS_W(PWS_W),
        .CNT_W(NCO_CNT_W)
    ) u_pulse (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ctrl(ctrl_ff),
        .pulse_width_sel(pws_ff),
        .accumulator_carry(carry), // see RL4
        .raw_level(raw_level)
    );

    // polarity is the last stage, so the status bit shows the pin level
    assign nxt_out = raw_level ^ ctrl_ff.output_invert; // see RL3

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    // read data
    function automatic logic [NCO_DW-1:0] reg_read(
        logic [NCO_AW-1:0] a,
        nco_ctrl_t c,
        logic level,
        logic [ACC_W-1:0] inc,
        logic [PWS_W-1:0] pws,
        logic [ACC_W-1:0] acc
    );
        logic [NCO_DW-1:0] d;
        d = NCO_RST_BYTE;
        unique case (a)
            NCO_ADDR_CON: d = nco_con_byte(c, level); // see RL2
            NCO_ADDR_INCL: d = inc[NCO_DW-1:0];
            NCO_ADDR_INCH: d = inc[2*NCO_DW-1:NCO_DW];
            NCO_ADDR_INCU: d = NCO_DW'(inc[ACC_W-1:2*NCO_DW]);
            NCO_ADDR_PWS: d = NCO_DW'(pws);
            NCO_ADDR_ACCL: d = acc[NCO_DW-1:0];
            NCO_ADDR_ACCH: d = acc[2*NCO_DW-1:NCO_DW];
            NCO_ADDR_ACCU: d = NCO_DW'(acc[ACC_W-1:2*NCO_DW]);
        endcase
        return d;
    endfunction

    // data stand one cycle after the strobe and read zero otherwise
    assign nxt_rdata = reg_rd ? reg_read(reg_addr, ctrl_ff, out_ff,
                                         inc_staged, pws_ff, acc_ff)
                              : NCO_RST_BYTE; // see RL5

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= NCO_RST_BYTE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign nco_out = out_ff;
    assign accumulator_carry = carry_ff;

    // checks
    a_stop_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrl_ff.osc_enable |=> acc_ff == $past(acc_ff)) // see RL1
        else $error("accumulator moved while stopped");

    a_status_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == NCO_ADDR_CON
        |=> reg_rdata[NCO_BIT_OUT] == $past(out_ff)) // see RL2
        else $error("status bit differs from output level");

    a_polarity_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 out_ff == ($past(raw_level) ^ $past(ctrl_ff.output_invert)))
        // see RL3
        else $error("output polarity wrong");

    a_mode_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_ff.osc_enable && ctrl_ff.pulse_frequency_select && carry
        |=> raw_level ##1 out_ff != $past(ctrl_ff.output_invert)) // see RL4
        else $error("pulse mode did not drive active level");

    a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == NCO_ADDR_CON
        |=> (reg_rdata & ~NCO_CON_RMASK) == NCO_RST_BYTE) // see RL5
        else $error("unused control bits read nonzero");

    a_acc_add: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_ff.osc_enable
        |=> acc_ff == ACC_W'($past(acc_ff) + $past(inc_buf_ff))) // see RL6
        else $error("accumulator did not add increment");

    a_carry_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_ff.osc_enable && acc_ff > ACC_W'(~inc_buf_ff)
        |=> accumulator_carry) // see RL6
        else $error("overflow not flagged");

    a_reset_clear: assert property (@(posedge clk_sys)
        !rst_n |-> acc_ff == '0 && ctrl_ff == NCO_CTRL_RST
        && out_ff == 1'b0 && rdata_ff == NCO_RST_BYTE) // see RL9
        else $error("register not cleared by reset");

    a_write_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_con ##1 reg_rd && reg_addr == NCO_ADDR_CON
        |=> reg_rdata[NCO_BIT_EN] == $past(reg_wdata[NCO_BIT_EN], 2)
        && reg_rdata[NCO_BIT_OUT] == $past(out_ff)
        && (reg_rdata & ~NCO_CON_RMASK) == NCO_RST_BYTE) // see RL10
        else $error("write reached a read-only control bit");

    c_fdc_toggle: cover property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_ff.osc_enable && !ctrl_ff.pulse_frequency_select && carry);

    c_long_pulse: cover property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_ff.pulse_frequency_select && carry && pws_ff != '0
        ##1 raw_level [*3]);

    c_live_reload: cover property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_ff.osc_enable && wr_incl ##2 inc_buf_ff == inc_staged);

    c_invert_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_ff.output_invert && reg_rd && reg_addr == NCO_ADDR_CON);

endmodule // nco_core

// ### verification/tb_nco_control_register.sv
// self-checking bench for the oscillator control register block
`timescale 1ns/1ns
module tb_nco_control_register;
    import nco_pkg::*;

    logic clk_sys;
    logic arst_n;
    logic [NCO_AW-1:0] reg_addr;
    logic [NCO_DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [NCO_DW-1:0] reg_rdata;
    logic nco_out;
    logic accumulator_carry;
    int errors;
    int checked;

    nco_core dut (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .nco_out(nco_out),
        .accumulator_carry(accumulator_carry)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic end_sim;
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // called right after a rising edge; a write after a write lets one
    // edge pass so the strobe is never set twice in one step
    task automatic wr(input logic [NCO_AW-1:0] a, input logic [7:0] d);
        if (reg_wr) @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge; they are
    // taken at the edge that closes that cycle
    task automatic rd(input logic [NCO_AW-1:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask

    task automatic wait_carry;
        int i;
        for (i = 0; i < 100 && accumulator_carry !== 1'b1; i++) begin
            @(negedge clk_sys);
        end
        if (accumulator_carry !== 1'b1) begin
            errors++;
            end_sim();
        end
    endtask

    task automatic t_reset;
        logic [7:0] d;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            chk(d, 8'h00);
        end
        wr(NCO_ADDR_INCU, 8'hff);
        rd(NCO_ADDR_INCU, d);
        chk(d, 8'h0f);
        wr(NCO_ADDR_PWS, 8'hff);
        rd(NCO_ADDR_PWS, d);
        chk(d, 8'h07);
        // accumulator is read only here
        wr(NCO_ADDR_ACCL, 8'h55);
        rd(NCO_ADDR_ACCL, d);
        chk(d, 8'h00);
    endtask

    task automatic t_status;
        logic [7:0] d;
        wr(NCO_ADDR_CON, 8'h7e);
        // back to back: the status bit still shows the level before
        rd(NCO_ADDR_CON, d);
        chk(d, 8'h10);
        repeat (3) @(negedge clk_sys);
        chk({7'h00, nco_out}, 8'h01);
        @(posedge clk_sys);
        rd(NCO_ADDR_CON, d);
        chk(d, 8'h30);
        wr(NCO_ADDR_CON, 8'h00);
        repeat (3) @(posedge clk_sys);
        rd(NCO_ADDR_CON, d);
        chk(d, 8'h00);
    endtask

    // increment of half the range wraps every second clock
    task automatic t_fdc;
        logic prev;
        logic prev_c;
        int n;
        wr(NCO_ADDR_INCU, 8'h08);
        wr(NCO_ADDR_INCH, 8'h00);
        wr(NCO_ADDR_INCL, 8'h00);
        wr(NCO_ADDR_CON, 8'h80);
        repeat (4) @(negedge clk_sys);
        prev = nco_out;
        prev_c = accumulator_carry;
        n = 0;
        repeat (40) begin
            @(negedge clk_sys);
            if (accumulator_carry === 1'b1) n++;
            // the output moves one edge after the carry flag rises
            chk({7'h00, nco_out ^ prev}, {7'h00, prev_c});
            prev = nco_out;
            prev_c = accumulator_carry;
        end
        chk(8'(n), 8'd20);
    endtask

    task automatic t_hold;
        logic [7:0] a;
        logic [7:0] b;
        int n;
        @(posedge clk_sys);
        wr(NCO_ADDR_CON, 8'h00);
        wr(NCO_ADDR_INCU, 8'h01);
        wr(NCO_ADDR_INCL, 8'h00);
        wr(NCO_ADDR_CON, 8'h80);
        repeat (3) @(posedge clk_sys);
        // two reads are two clocks apart, so the top nibble moves by two
        rd(NCO_ADDR_ACCU, a);
        rd(NCO_ADDR_ACCU, b);
        chk((b - a) & 8'h0f, 8'h02);
        wr(NCO_ADDR_CON, 8'h00);
        rd(NCO_ADDR_ACCU, a);
        n = 0;
        repeat (20) begin
            @(negedge clk_sys);
            if (accumulator_carry === 1'b1) n++;
        end
        @(posedge clk_sys);
        rd(NCO_ADDR_ACCU, b);
        chk(b, a);
        chk(8'(n), 8'h00);
    endtask

    // overflow every 16 clocks, longest pulse tried is 8
    task automatic t_pfm(input int pws);
        logic pol;
        int n;
        pol = pws[0];
        @(posedge clk_sys);
        wr(NCO_ADDR_CON, 8'h00);
        wr(NCO_ADDR_PWS, 8'(pws));
        wr(NCO_ADDR_CON, {3'b100, pol, 4'b0001});
        @(negedge clk_sys);
        wait_carry();
        // the pin follows the carry flag by one edge
        @(negedge clk_sys);
        n = 0;
        for (int i = 0; i < 40 && nco_out !== pol; i++) begin
            n++;
            @(negedge clk_sys);
        end
        chk(8'(n), 8'(1 << pws));
    endtask

    task automatic t_rst;
        logic [7:0] d;
        @(posedge clk_sys);
        wr(NCO_ADDR_CON, 8'h91);
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk({7'h00, nco_out}, 8'h00);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(NCO_ADDR_CON, d);
        chk(d, 8'h00);
        rd(NCO_ADDR_INCU, d);
        chk(d, 8'h00);
        rd(NCO_ADDR_PWS, d);
        chk(d, 8'h00);
    endtask

    initial begin
        errors = 0;
        checked = 0;
        arst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_status();
        t_fdc();
        t_hold();
        for (int p = 0; p < 4; p++) begin
            t_pfm(p);
        end
        t_rst();
        end_sim();
    end

endmodule // tb_nco_control_register
